// File: verilog/dss_pkg.sv
// Constants and types shared by the start/stop sequencer.
// Assumes a single control clock and a synchronous, active-low reset.
package dss_pkg;

    // One-hot sequencing states.
    typedef enum logic [7:0] {
        S_NOT_READY   = 8'h01,
        S_START_DIS   = 8'h02,
        S_START_EN    = 8'h04,
        S_STAGE_OPERABLE = 8'h08,
        S_ENABLED     = 8'h10,
        S_RAPID_STOP  = 8'h20,
        S_TRIP_ACTIVE = 8'h40,
        S_FAULT_LATCHED     = 8'h80
    } dss_state_t;

    // Reported sequencing state codes.
    localparam logic [2:0] CODE_NOT_READY = 3'h0;
    localparam logic [2:0] CODE_START_DIS = 3'h1;
    localparam logic [2:0] CODE_START_EN = 3'h2;
    localparam logic [2:0] CODE_STAGE_OPERABLE = 3'h3;
    localparam logic [2:0] CODE_ENABLED = 3'h4;
    localparam logic [2:0] CODE_RAPID_STOP = 3'h5;
    localparam logic [2:0] CODE_TRIP_ACTIVE = 3'h6;
    localparam logic [2:0] CODE_FAULT_LATCHED = 3'h7;

    // Values after reset.
    localparam logic RST_STAGE_OPERABLE = 1'h1;
    localparam logic RST_ENTRY_PULSE = 1'h1;
    localparam logic RST_HEALTHY = 1'h0;
    localparam logic RST_CONTACTOR = 1'h0;
    localparam logic RST_INIT = 1'h1;

endpackage

// File: verilog/dss_sequencer.sv
// Start/stop sequencer for a motor inverter: commands in, stage and ramp controls and status out.
// Assumes all inputs come from logic on clk; zero_speed comes from the ramp, trip_in from protection.
//
// Overview of operation
// - Forward run command with running permitted runs the motor forward.
// - Reverse run command with running permitted runs the motor in reverse.
// - Stop input high latches run commands; stop input low clears the latch.
// - Inch command runs at inch speed; releasing it ramps to zero.
// - Operation enable low while running disables the stage at once; motor coasts.
// - Rapid-stop low while running or inching ramps to zero at rapid-stop rate.
// - After a rapid stop, no restart until its ramp completes.
// - Freewheel-stop low disables the stage; no restart until the coast completes.
// - Remote direction-invert input inverts the demanded rotation direction.
// - Rising edge of fault-clear clears latched trips; a held level does not.
// - With clear-faults-on-run set, a run command rising edge clears trips.
// - Auto-start lets a run present at power-up start; otherwise a new edge needed.
// - Fault-latched output is high exactly while a latched trip exists.
// - Active output marks the enabled state; inching output marks inch mode.
// - Decelerating output is high throughout a ramped or rapid stop, not during a coast or a trip.
// - Contactor output is closed except after a trip or outside operation.
// - Run-acceptable output is high whenever a run command would be accepted.
// - Stage-operable output is high when the stage is operable and would run.
// - Run-accepted output is high once a run command has been accepted.
// - Entry pulse is high one cycle on each entry to run or inch.
// - Sequencing state is coded 0 not ready through 7 fault_latched.
// - Direction demand combines direction invert and reverse command, not actual rotation.
// - Health flag falls on a trip and rises once run is removed, or in the first cycle after reset.
// - Commands count only in remote mode with enable, stop inputs and health high.
// - Forward and reverse together are both ignored and the drive stops.
module dss_sequencer import dss_pkg::*; (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Commands from the application.
    input wire logic remote_mode,
    input wire logic forward_run_cmd,
    input wire logic backward_run_cmd,
    input wire logic stop_n,
    input wire logic inch_cmd,
    input wire logic op_enable,
    input wire logic rapid_stop_n,
    input wire logic freewheel_stop_n,
    input wire logic remote_dir_invert,
    input wire logic remote_fault_clear,
    // Options.
    input wire logic clear_faults_on_run,
    input wire logic auto_start,
    // Power stage and ramp feedback.
    input wire logic trip_in,
    input wire logic zero_speed,
    // Controls to the power stage and ramp.
    output logic stage_enable,
    output logic reverse_run,
    output logic inch_speed_sel,
    output logic ramp_to_zero,
    output logic rapid_rate_sel,
    output logic contactor_close,
    // Status.
    output logic fault_latched,
    output logic run_active,
    output logic inch_active,
    output logic decelerating,
    output logic run_acceptable,
    output logic stage_operable,
    output logic run_accepted,
    output logic entry_pulse,
    output logic [2:0] sequencing_state,
    output logic direction_demand,
    output logic healthy
);

    dss_state_t state_q, state_d;
    logic init_q;
    logic run_prev_q;
    logic clear_prev_q;
    logic latch_q;
    logic latch_dir_q;
    logic arm_q;
    logic inch_q, inch_d;
    logic stopping_q, stopping_d;
    logic fault_q;
    logic healthy_q;
    logic boot_run_q;

    logic run_req;
    logic run_level;
    logic run_rise;
    logic run_dir;
    logic permit;
    logic stops_ok;
    logic fault_clear;

    // Both directions at once count as no command.
    assign run_req = remote_mode && (forward_run_cmd ^ backward_run_cmd);
    assign run_level = run_req || latch_q;
    assign run_rise = run_req && !run_prev_q && !init_q;
    assign run_dir = latch_q && !run_req ? latch_dir_q : backward_run_cmd;
    assign stops_ok = rapid_stop_n && freewheel_stop_n;
    assign permit = remote_mode && op_enable && stops_ok && healthy_q;
    assign fault_clear = (remote_fault_clear && !clear_prev_q)
        || (clear_faults_on_run && run_rise);

    // Edge history; in the first cycle after reset a present run only counts with auto-start.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            init_q <= RST_INIT;
            run_prev_q <= 1'b0;
            clear_prev_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
            run_prev_q <= (init_q && auto_start) ? 1'b0 : run_req;
            clear_prev_q <= remote_fault_clear;
        end
    end

    // Run latch, held while stop input is high.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_q <= 1'b0;
            latch_dir_q <= 1'b0;
        end else if (!stop_n || (remote_mode && forward_run_cmd && backward_run_cmd)) begin
            latch_q <= 1'b0;
        end else if (run_req) begin
            latch_q <= 1'b1;
            latch_dir_q <= backward_run_cmd;
        end
    end

    // A run start needs a fresh edge, an inch start only the inch level; armed until the command goes away.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arm_q <= 1'b0;
        end else if (!run_level && !(remote_mode && inch_cmd)) begin
            arm_q <= 1'b0;
        end else if (run_rise || (remote_mode && inch_cmd && !run_level)) begin
            arm_q <= 1'b1;
        end
    end

    // Latched trips; a new trip wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
        end else if (trip_in) begin
            fault_q <= 1'b1;
        end else if (fault_clear) begin
            fault_q <= 1'b0;
        end
    end

    // Health falls on a trip and recovers once no run is demanded.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            healthy_q <= RST_HEALTHY;
        end else if (trip_in) begin
            healthy_q <= 1'b0;
        end else if (!run_level || init_q) begin
            healthy_q <= 1'b1;
        end
    end

    // With auto-start, a run held through reset may pass start disabled once.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boot_run_q <= 1'b0;
        end else if (init_q) begin
            boot_run_q <= auto_start;
        end else if (!run_level || state_q == S_ENABLED) begin
            boot_run_q <= 1'b0;
        end
    end

    // Sequencing state machine.
    always_comb begin
        state_d = state_q;
        inch_d = inch_q;
        stopping_d = stopping_q;
        unique case (state_q)
            S_NOT_READY: begin
                state_d = S_START_DIS;
            end
            S_START_DIS: begin
                // A coast or rapid stop must see zero speed before a restart.
                if (stops_ok && !fault_q && healthy_q && zero_speed && (!run_level || boot_run_q)) begin
                    state_d = S_START_EN;
                end
            end
            S_START_EN: begin
                if (!stops_ok) begin
                    state_d = S_START_DIS;
                end else if (arm_q && permit && (run_level || inch_cmd)) begin
                    state_d = S_STAGE_OPERABLE;
                end
            end
            S_STAGE_OPERABLE: begin
                if (!permit || !arm_q) begin
                    state_d = S_START_EN;
                end else if (run_level) begin
                    state_d = S_ENABLED;
                    inch_d = 1'b0;
                    stopping_d = 1'b0;
                end else if (inch_cmd) begin
                    state_d = S_ENABLED;
                    inch_d = 1'b1;
                    stopping_d = 1'b0;
                end else begin
                    state_d = S_START_EN;
                end
            end
            S_ENABLED: begin
                if (!freewheel_stop_n || !op_enable) begin
                    state_d = S_START_DIS;
                end else if (!rapid_stop_n) begin
                    state_d = S_RAPID_STOP;
                end else if (!stopping_q && (inch_q ? !inch_cmd : !run_level)) begin
                    stopping_d = 1'b1;
                end else if (stopping_q && zero_speed) begin
                    state_d = S_START_EN;
                    stopping_d = 1'b0;
                    inch_d = 1'b0;
                end
            end
            S_RAPID_STOP: begin
                if (!freewheel_stop_n || !op_enable) begin
                    state_d = S_START_DIS;
                end else if (zero_speed) begin
                    state_d = S_START_DIS;
                end
            end
            S_TRIP_ACTIVE: begin
                if (zero_speed) begin
                    state_d = S_FAULT_LATCHED;
                end
            end
            S_FAULT_LATCHED: begin
                if (!fault_q) begin
                    state_d = S_START_DIS;
                end
            end
            default: begin
                state_d = S_NOT_READY;
            end
        endcase
        if (trip_in && state_q != S_FAULT_LATCHED) begin
            state_d = S_TRIP_ACTIVE;
        end
        if (state_d != S_ENABLED) begin
            inch_d = 1'b0;
            stopping_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= S_NOT_READY;
            inch_q <= 1'b0;
            stopping_q <= 1'b0;
        end else begin
            state_q <= state_d;
            inch_q <= inch_d;
            stopping_q <= stopping_d;
        end
    end

    // Stage and ramp controls, registered from the next state; reverse_run from the run direction and invert.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage_enable <= 1'b0;
            reverse_run <= 1'b0;
            inch_speed_sel <= 1'b0;
            ramp_to_zero <= 1'b0;
            rapid_rate_sel <= 1'b0;
            contactor_close <= RST_CONTACTOR;
        end else begin
            stage_enable <= state_d == S_ENABLED || state_d == S_RAPID_STOP;
            reverse_run <= run_dir ^ remote_dir_invert;
            inch_speed_sel <= inch_d;
            ramp_to_zero <= stopping_d || state_d == S_RAPID_STOP;
            rapid_rate_sel <= state_d == S_RAPID_STOP;
            contactor_close <= !(state_d == S_TRIP_ACTIVE || state_d == S_FAULT_LATCHED
                || state_d == S_NOT_READY);
        end
    end

    // Status outputs.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_active <= 1'b0;
            inch_active <= 1'b0;
            decelerating <= 1'b0;
            run_acceptable <= 1'b0;
            stage_operable <= RST_STAGE_OPERABLE;
            run_accepted <= 1'b0;
            entry_pulse <= RST_ENTRY_PULSE;
            direction_demand <= 1'b0;
        end else begin
            run_active <= state_d == S_ENABLED;
            inch_active <= inch_d;
            decelerating <= stopping_d || state_d == S_RAPID_STOP;
            run_acceptable <= state_d == S_START_EN;
            stage_operable <= state_d == S_STAGE_OPERABLE || state_d == S_ENABLED;
            run_accepted <= state_d == S_STAGE_OPERABLE || state_d == S_ENABLED;
            entry_pulse <= state_d == S_ENABLED && state_q != S_ENABLED;
            direction_demand <= run_dir ^ remote_dir_invert;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sequencing_state <= CODE_NOT_READY;
        end else begin
            unique case (state_d)
                S_NOT_READY: sequencing_state <= CODE_NOT_READY;
                S_START_DIS: sequencing_state <= CODE_START_DIS;
                S_START_EN: sequencing_state <= CODE_START_EN;
                S_STAGE_OPERABLE: sequencing_state <= CODE_STAGE_OPERABLE;
                S_ENABLED: sequencing_state <= CODE_ENABLED;
                S_RAPID_STOP: sequencing_state <= CODE_RAPID_STOP;
                S_TRIP_ACTIVE: sequencing_state <= CODE_TRIP_ACTIVE;
                default: sequencing_state <= CODE_FAULT_LATCHED;
            endcase
        end
    end

    assign fault_latched = fault_q;
    assign healthy = healthy_q;

    // Checks.
    property p_fault_set;
        @(posedge clk) disable iff (!rst_n) trip_in |=> fault_latched && !healthy;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("trip not latched");

    property p_fault_clear;
        @(posedge clk) disable iff (!rst_n)
            $rose(remote_fault_clear) && !trip_in && !init_q |=> !fault_latched;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault clear edge ignored");

    property p_health_back;
        @(posedge clk) disable iff (!rst_n)
            !healthy && !trip_in && !run_level |=> healthy;
    endproperty
    a_health_back: assert property (p_health_back) else $error("health not restored");

    property p_coast;
        @(posedge clk) disable iff (!rst_n) run_active && !op_enable |=> !stage_enable && !run_active;
    endproperty
    a_coast: assert property (p_coast) else $error("enable low did not coast");

    property p_freewheel;
        @(posedge clk) disable iff (!rst_n) !freewheel_stop_n |=> !stage_enable;
    endproperty
    a_freewheel: assert property (p_freewheel) else $error("freewheel stop ignored");

    sequence s_rapid_req;
        run_active && !rapid_stop_n && freewheel_stop_n && op_enable && !trip_in;
    endsequence
    property p_rapid;
        @(posedge clk) disable iff (!rst_n)
            s_rapid_req |=> sequencing_state == 3'h5 && rapid_rate_sel && decelerating;
    endproperty
    a_rapid: assert property (p_rapid) else $error("rapid stop not entered");

    property p_rapid_hold;
        @(posedge clk) disable iff (!rst_n)
            sequencing_state == 3'h5 && !zero_speed && freewheel_stop_n && op_enable && !trip_in
            |=> sequencing_state == 3'h5;
    endproperty
    a_rapid_hold: assert property (p_rapid_hold) else $error("rapid stop left early");

    property p_entry;
        @(posedge clk) disable iff (!rst_n) entry_pulse && !init_q |-> run_active ##1 !entry_pulse;
    endproperty
    a_entry: assert property (p_entry) else $error("entry pulse wrong");

    property p_code;
        @(posedge clk) disable iff (!rst_n) (sequencing_state == 3'h4) == run_active;
    endproperty
    a_code: assert property (p_code) else $error("state code mismatch");

    property p_contactor;
        @(posedge clk) disable iff (!rst_n) trip_in |=> !contactor_close && sequencing_state == 3'h6;
    endproperty
    a_contactor: assert property (p_contactor) else $error("contactor not opened on trip");

endmodule

// File: bench/dss_ramp_model.sv
// Ramp and motor model on the far side of the sequencer; speed is an abstract count.
// Assumes the sequencer's clock and reset; zero_speed is decoded from the registered speed count.
module dss_ramp_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Controls from the sequencer.
    input wire logic stage_enable,
    input wire logic ramp_to_zero,
    input wire logic rapid_rate_sel,
    // Feedback.
    output logic zero_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] speed_q;
    // Rapid stops shed four steps a cycle so a stop takes several cycles either way.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            speed_q <= 5'h00;
        end else if (stage_enable && !ramp_to_zero) begin
            speed_q <= (speed_q == 5'h10) ? speed_q : speed_q + 5'h01;
        end else if (rapid_rate_sel) begin
            speed_q <= (speed_q > 5'h04) ? speed_q - 5'h04 : 5'h00;
        end else if (speed_q != 5'h00) begin
            speed_q <= speed_q - 5'h01;
        end
    end
    assign zero_speed = (speed_q == 5'h00);
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the start/stop sequencer with a ramp model on its far side.
// Assumes a 100 MHz clock; inputs change by non-blocking assignment at rising edges.
module tb_top import dss_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, remote_mode, forward_run_cmd, backward_run_cmd, stop_n, inch_cmd;
    logic op_enable, rapid_stop_n, freewheel_stop_n, remote_dir_invert, remote_fault_clear;
    logic clear_faults_on_run, auto_start, trip_in, zero_speed, stage_enable, reverse_run;
    logic inch_speed_sel, ramp_to_zero, rapid_rate_sel, contactor_close, fault_latched;
    logic run_active, inch_active, decelerating, run_acceptable, stage_operable;
    logic run_accepted, entry_pulse, direction_demand, healthy, rv, iv;
    logic [2:0] sequencing_state;
    int err_total, check_count, i;

    dss_sequencer dss_sequencer_inst (
        .clk, .rst_n, .remote_mode, .forward_run_cmd, .backward_run_cmd, .stop_n, .inch_cmd,
        .op_enable, .rapid_stop_n, .freewheel_stop_n, .remote_dir_invert, .remote_fault_clear,
        .clear_faults_on_run, .auto_start, .trip_in, .zero_speed, .stage_enable, .reverse_run,
        .inch_speed_sel, .ramp_to_zero, .rapid_rate_sel, .contactor_close, .fault_latched,
        .run_active, .inch_active, .decelerating, .run_acceptable, .stage_operable,
        .run_accepted, .entry_pulse, .sequencing_state, .direction_demand, .healthy
    );
    dss_ramp_model dss_ramp_model_inst (
        .clk, .rst_n, .stage_enable, .ramp_to_zero, .rapid_rate_sel, .zero_speed
    );

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    function automatic logic exp_dir(input logic rev, input logic inv);
        return rev ^ inv;
    endfunction

    task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Polls at falling edges so registered outputs have settled.
    task automatic wait_code(input logic [2:0] code, input int lim);
        int n;
        n = 0;
        while (sequencing_state !== code && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk("state", sequencing_state, code);
    endtask

    // Stop low for a few cycles clears any latched run before returning to idle.
    task automatic go_idle;
        @(posedge clk);
        {forward_run_cmd, backward_run_cmd, inch_cmd, trip_in, remote_fault_clear, stop_n} <= 6'h00;
        {op_enable, rapid_stop_n, freewheel_stop_n, remote_mode} <= 4'hF;
        repeat (3) @(posedge clk);
        stop_n <= 1'h1;
        wait_code(CODE_START_EN, 200);
    endtask

    task automatic start_run(input logic rev, input logic inv);
        @(posedge clk);
        remote_dir_invert <= inv;
        forward_run_cmd <= !rev;
        backward_run_cmd <= rev;
        wait_code(CODE_ENABLED, 10);
    endtask

    task automatic pulse_trip;
        @(posedge clk) trip_in <= 1'h1;
        @(posedge clk) trip_in <= 1'h0;
        @(negedge clk);
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        err_total++;
        $display("BAD watchdog expected finish seen hang");
        print_verdict();
    end

    initial begin
        void'($urandom(32'h5E5A));
        {rst_n, forward_run_cmd, backward_run_cmd, inch_cmd, trip_in, remote_fault_clear} = 6'h00;
        {remote_dir_invert, clear_faults_on_run, auto_start} = 3'h0;
        {stop_n, op_enable, rapid_stop_n, freewheel_stop_n, remote_mode} = 5'h1F;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk("rst code", sequencing_state, CODE_NOT_READY);
        chk("rst operable", stage_operable, RST_STAGE_OPERABLE);
        chk("rst pulse", entry_pulse, RST_ENTRY_PULSE);
        chk("rst contactor", contactor_close, RST_CONTACTOR);
        @(posedge clk) rst_n <= 1'h1;
        wait_code(CODE_START_DIS, 4);
        wait_code(CODE_START_EN, 10);
        chk("contactor", contactor_close, 1'h1);
        chk("acceptable", run_acceptable, 1'h1);
        chk("healthy", healthy, 1'h1);
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            {remote_mode, op_enable, rapid_stop_n, freewheel_stop_n, backward_run_cmd} <= 5'h1E ^ (5'h10 >> i);
            forward_run_cmd <= 1'h1;
            cyc(6);
            chk("refused", stage_enable, 1'h0);
            go_idle();
        end
        for (i = 0; i < 6; i++) begin
            rv = (i < 4) ? i[0] : 1'($urandom);
            iv = (i < 4) ? i[1] : 1'($urandom);
            start_run(rv, iv);
            chk("entry", entry_pulse, 1'h1);
            chk("active", run_active, 1'h1);
            chk("stage", stage_enable, 1'h1);
            chk("reverse", reverse_run, exp_dir(rv, iv));
            chk("dir", direction_demand, exp_dir(rv, iv));
            chk("accepted", run_accepted, 1'h1);
            chk("operable", stage_operable, 1'h1);
            cyc(1);
            chk("entry end", entry_pulse, 1'h0);
            cyc($urandom_range(9, 2));
            @(posedge clk) {forward_run_cmd, backward_run_cmd} <= 2'h0;
            cyc(5);
            chk("latched", run_active, 1'h1);
            @(posedge clk) stop_n <= 1'h0;
            cyc(3);
            chk("stopping", decelerating, 1'h1);
            chk("unlatch", ramp_to_zero, 1'h1);
            go_idle();
        end
        @(posedge clk) inch_cmd <= 1'h1;
        wait_code(CODE_ENABLED, 10);
        chk("inch entry", entry_pulse, 1'h1);
        chk("inching", inch_active, 1'h1);
        chk("inch ref", inch_speed_sel, 1'h1);
        cyc(4);
        @(posedge clk) inch_cmd <= 1'h0;
        cyc(2);
        chk("inch ramp", ramp_to_zero, 1'h1);
        go_idle();
        start_run(1'h0, 1'h0);
        cyc(6);
        @(posedge clk) backward_run_cmd <= 1'h1;
        cyc(3);
        chk("both", decelerating, 1'h1);
        go_idle();
        start_run(1'h0, 1'h0);
        cyc(16);
        @(posedge clk) rapid_stop_n <= 1'h0;
        cyc(2);
        chk("rapid", sequencing_state, CODE_RAPID_STOP);
        chk("rapid rate", rapid_rate_sel, 1'h1);
        chk("rapid ramp", ramp_to_zero, 1'h1);
        @(posedge clk) rapid_stop_n <= 1'h1;
        cyc(2);
        chk("no restart", sequencing_state, CODE_RAPID_STOP);
        wait_code(CODE_START_DIS, 20);
        go_idle();
        for (i = 0; i < 2; i++) begin
            start_run(1'h0, 1'h0);
            cyc(14);
            @(posedge clk) {freewheel_stop_n, op_enable} <= i ? 2'h1 : 2'h2;
            cyc(2);
            chk("coast", stage_enable, 1'h0);
            @(posedge clk) {freewheel_stop_n, op_enable} <= 2'h3;
            cyc(2);
            chk("coast hold", stage_enable, 1'h0);
            go_idle();
        end
        start_run(1'h0, 1'h0);
        pulse_trip();
        chk("trip", sequencing_state, CODE_TRIP_ACTIVE);
        chk("trip contactor", contactor_close, 1'h0);
        chk("fault", fault_latched, 1'h1);
        chk("unhealthy", healthy, 1'h0);
        wait_code(CODE_FAULT_LATCHED, 40);
        @(posedge clk) remote_fault_clear <= 1'h1;
        cyc(2);
        chk("cleared", fault_latched, 1'h0);
        chk("run held", healthy, 1'h0);
        pulse_trip();
        cyc(3);
        chk("level held", fault_latched, 1'h1);
        @(posedge clk) {forward_run_cmd, remote_fault_clear, stop_n} <= 3'h0;
        cyc(3);
        chk("healthy again", healthy, 1'h1);
        @(posedge clk) remote_fault_clear <= 1'h1;
        cyc(2);
        chk("new edge", fault_latched, 1'h0);
        go_idle();
        @(posedge clk) clear_faults_on_run <= 1'h1;
        pulse_trip();
        wait_code(CODE_FAULT_LATCHED, 40);
        @(posedge clk) forward_run_cmd <= 1'h1;
        cyc(2);
        chk("run clears", fault_latched, 1'h0);
        @(posedge clk) clear_faults_on_run <= 1'h0;
        go_idle();
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            rst_n <= 1'h0;
            auto_start <= i[0];
            forward_run_cmd <= 1'h1;
            repeat (4) @(posedge clk);
            rst_n <= 1'h1;
            cyc(25);
            chk("power-up run", run_active, i[0]);
            go_idle();
        end
        start_run(1'h0, 1'h0);
        go_idle();
        print_verdict();
    end
endmodule
